/* verilog/cam_mask_irq.sv */
// Acceptance masking, error counters and interrupt bookkeeping with an APB slave
// How it works
// (RQ1) Mask bit 0: identifier bit must equal the stored buffer bit to accept.
// (RQ2) Mask bit 1: bit is don't-care and stored bit takes the received value.
// (RQ3) Global mask is two 16-bit registers used as one 32-bit value.
// (RQ4) Extended frames use all global bits; RTR mask on SRR, EXTENDED_REMOTE_MASK on RTR.
// (RQ5) Standard frames use global bits 28..18 on ID 10..0, plus RTR and IDE.
// (RQ6) Buffer 14 is filtered by a separate 32-bit basic mask, same semantics.
// (RQ7) Extended frames on buffer 14 use all basic bits, mapped like global.
// (RQ8) Standard frames on buffer 14 use basic bits 28..18, RTR and IDE only.
// (RQ9) Lower mask half holds ID mask bits 14..0 at 15..1, EXTENDED_REMOTE_MASK at 0.
// (RQ10) Enable bit 15 lets error counter changes raise an error interrupt.
// (RQ11) Enable bits 14..0 enable buffers 14..0 as interrupt sources.
// (RQ12) Error pending sets on any counter change and holds until cleared.
// (RQ13) A buffer's pending bit sets after its successful transmit or receive.
// (RQ14) Writing 1 to a clear bit clears that pending bit; 0 has no effect.
// (RQ15) Software writes the clear register with whole stores, never read-modify-write.
// (RQ16) Code enable bits choose which pending flags may form the status code.
// (RQ17) Node state codes: 000 off, 010 active, 011 warning, 10X passive, 11X bus off.
// (RQ18) Status flag and code name the highest pending, code-enabled source.
// (RQ19) Flag 0 when none; code 0000 is error, 0001..1111 are buffers 0..14.
// (RQ20) Receive and transmit error counters are kept and readable.
// (RQ21) Interrupt output is high while any enabled source is pending.
// (RQ22) Error source wins, then buffers in ascending number order.
module cam_mask_irq
  import cam_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic node_enable,
  input wire logic match_req,
  input wire logic match_use_basic,
  input wire logic frame_ide,
  input wire logic [28:0] frame_id,
  input wire logic frame_srr,
  input wire logic frame_rtr,
  input wire logic [31:0] stored_word,
  output logic match_valid,
  output logic match_accept,
  output logic [31:0] match_word,
  input wire logic [14:0] buffer_done,
  input wire logic rx_err_inc_one,
  input wire logic rx_err_inc_big,
  input wire logic rx_err_dec,
  input wire logic tx_err_inc_big,
  input wire logic tx_err_dec,
  input wire logic bus_off_recover,
  output logic can_irq
);

  logic [15:0] gmask_base_q;
  logic [15:0] gmask_ext_q;
  logic [15:0] bmask_base_q;
  logic [15:0] bmask_ext_q;
  logic [15:0] int_enable_q;
  logic [15:0] int_pending_q;
  logic [15:0] int_code_en_q;
  logic [8:0] rx_err_count_q;
  logic [8:0] tx_err_count_q;
  logic [8:0] rx_err_count_d;
  logic [8:0] tx_err_count_d;
  logic bus_off_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic match_valid_q;
  logic match_accept_q;
  logic [31:0] match_word_q;
  logic wr_en;
  logic rd_setup;
  logic [7:0] addr;
  logic [15:0] clear_bits;
  logic err_change;
  logic [2:0] node_state;
  logic [15:0] code_candidates;
  logic code_irq;
  logic [3:0] code_src;
  logic [31:0] sel_mask;
  logic [31:0] frame_word;
  logic [31:0] used_bits;
  logic [31:0] dont_care;
  logic [31:0] cmp_bits;
  logic [15:0] status_word;

  // Known register offset check, used only for the error answer; the read mux decodes on its own
  function automatic logic cam_mapped(input logic [7:0] a);
    case (a)
      CAM_ADDR_GMASK_BASE, CAM_ADDR_GMASK_EXT, CAM_ADDR_BMASK_BASE, CAM_ADDR_BMASK_EXT,
      CAM_ADDR_INT_ENABLE, CAM_ADDR_INT_PENDING, CAM_ADDR_INT_CLEAR, CAM_ADDR_INT_CODE_EN,
      CAM_ADDR_STATUS, CAM_ADDR_ERR_COUNT: cam_mapped = 1'b1;
      default: cam_mapped = 1'b0;
    endcase
  endfunction : cam_mapped

  // Saturating counter step, never wrapping through zero or past the top
  function automatic logic [8:0] cam_step(input logic [8:0] v, input logic [8:0] up,
                                          input logic down);
    logic [9:0] sum;
    sum = 10'(v) + 10'(up);
    if (up != 9'h000)
    begin
      cam_step = sum[9] ? 9'h1FF : sum[8:0];
    end
    else if (down && (v != 9'h000))
    begin
      cam_step = v - CAM_ERR_STEP_ONE;
    end
    else
    begin
      cam_step = v;
    end
  endfunction : cam_step

  // APB: zero wait states, read data captured in the setup phase
  assign addr = {paddr[7:2], 2'b00};
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign clear_bits = (wr_en && (addr == CAM_ADDR_INT_CLEAR)) ? pwdata[15:0] : 16'h0000; // [RQ14]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gmask_base_q <= CAM_RST_MASK_BASE;
      gmask_ext_q <= CAM_RST_MASK_EXT;
      bmask_base_q <= CAM_RST_MASK_BASE;
      bmask_ext_q <= CAM_RST_MASK_EXT;
      int_enable_q <= CAM_RST_INT_ENABLE;
      int_code_en_q <= CAM_RST_INT_CODE_EN;
    end
    else if (wr_en)
    begin
      case (addr)
        CAM_ADDR_GMASK_BASE: gmask_base_q <= pwdata[15:0]; // [RQ3]
        CAM_ADDR_GMASK_EXT: gmask_ext_q <= pwdata[15:0]; // [RQ3] [RQ9]
        CAM_ADDR_BMASK_BASE: bmask_base_q <= pwdata[15:0]; // [RQ6]
        CAM_ADDR_BMASK_EXT: bmask_ext_q <= pwdata[15:0]; // [RQ6] [RQ9]
        CAM_ADDR_INT_ENABLE: int_enable_q <= pwdata[15:0]; // [RQ10] [RQ11]
        CAM_ADDR_INT_CODE_EN: int_code_en_q <= pwdata[15:0]; // [RQ16]
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (rd_setup)
    begin
      pslverr_q <= !cam_mapped(addr);
      case (addr)
        CAM_ADDR_GMASK_BASE: prdata_q <= {16'h0000, gmask_base_q};
        CAM_ADDR_GMASK_EXT: prdata_q <= {16'h0000, gmask_ext_q}; // [RQ9]
        CAM_ADDR_BMASK_BASE: prdata_q <= {16'h0000, bmask_base_q};
        CAM_ADDR_BMASK_EXT: prdata_q <= {16'h0000, bmask_ext_q}; // [RQ9]
        CAM_ADDR_INT_ENABLE: prdata_q <= {16'h0000, int_enable_q};
        CAM_ADDR_INT_PENDING: prdata_q <= {16'h0000, int_pending_q};
        CAM_ADDR_INT_CODE_EN: prdata_q <= {16'h0000, int_code_en_q};
        CAM_ADDR_STATUS: prdata_q <= {16'h0000, status_word};
        CAM_ADDR_ERR_COUNT: prdata_q <= {16'h0000, tx_err_count_q[7:0], rx_err_count_q[7:0]}; // [RQ20]
        default: prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Error counters; the top bit of the transmit count marks the bus-off threshold
  always_comb
  begin
    rx_err_count_d = cam_step(rx_err_count_q,
                              rx_err_inc_big ? CAM_ERR_STEP_BIG :
                              (rx_err_inc_one ? CAM_ERR_STEP_ONE : 9'h000),
                              rx_err_dec);
    tx_err_count_d = cam_step(tx_err_count_q, tx_err_inc_big ? CAM_ERR_STEP_BIG : 9'h000,
                              tx_err_dec);
    if (bus_off_recover)
    begin
      rx_err_count_d = 9'h000;
      tx_err_count_d = 9'h000;
    end
    else if (rx_err_count_d >= CAM_ERR_BUSOFF_LVL)
    begin
      // Receive count stops one below the bus-off level; it never forces bus off
      rx_err_count_d = CAM_ERR_BUSOFF_LVL - CAM_ERR_STEP_ONE;
    end
  end

  assign err_change = (rx_err_count_d != rx_err_count_q) || (tx_err_count_d != tx_err_count_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_err_count_q <= 9'h000;
      tx_err_count_q <= 9'h000;
      bus_off_q <= 1'b0;
    end
    else
    begin
      rx_err_count_q <= rx_err_count_d; // [RQ20]
      tx_err_count_q <= tx_err_count_d; // [RQ20]
      if (bus_off_recover)
      begin
        bus_off_q <= 1'b0;
      end
      else if (tx_err_count_d >= CAM_ERR_BUSOFF_LVL)
      begin
        bus_off_q <= 1'b1;
      end
    end
  end

  always_comb
  begin
    if (!node_enable)
    begin
      node_state = CAM_NS_NOT_ACTIVE; // [RQ17]
    end
    else if (bus_off_q)
    begin
      node_state = CAM_NS_BUS_OFF; // [RQ17]
    end
    else if ((rx_err_count_q >= CAM_ERR_PASSIVE_LVL) || (tx_err_count_q >= CAM_ERR_PASSIVE_LVL))
    begin
      node_state = CAM_NS_ERR_PASSIVE; // [RQ17]
    end
    else if ((rx_err_count_q >= CAM_ERR_WARN_LVL) || (tx_err_count_q >= CAM_ERR_WARN_LVL))
    begin
      node_state = CAM_NS_ERR_WARNING; // [RQ17]
    end
    else
    begin
      node_state = CAM_NS_ERR_ACTIVE; // [RQ17]
    end
  end

  // Pending flags: a new event in the clearing cycle keeps its bit set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_pending_q <= CAM_RST_INT_PENDING;
    end
    else
    begin
      int_pending_q[CAM_ERR_BIT] <= err_change ||
                                    (int_pending_q[CAM_ERR_BIT] && !clear_bits[CAM_ERR_BIT]); // [RQ12] [RQ14]
      int_pending_q[14:0] <= buffer_done | (int_pending_q[14:0] & ~clear_bits[14:0]); // [RQ13] [RQ14]
    end
  end

  // Error source first, then the lowest numbered buffer
  assign code_candidates = int_pending_q & int_code_en_q; // [RQ16]

  always_comb
  begin
    code_irq = 1'b0;
    code_src = CAM_CODE_ERROR;
    if (code_candidates[CAM_ERR_BIT])
    begin
      code_irq = 1'b1; // [RQ22]
      code_src = CAM_CODE_ERROR; // [RQ19]
    end
    else
    begin
      for (int i = CAM_NBUF - 1; i >= 0; i--)
      begin
        if (code_candidates[i])
        begin
          code_irq = 1'b1; // [RQ18]
          code_src = 4'(i + 1); // [RQ19] [RQ22]
        end
      end
    end
  end

  always_comb
  begin
    status_word = 16'h0000;
    status_word[CAM_ST_NS_LSB +: 3] = node_state;
    status_word[CAM_ST_IRQ] = code_irq; // [RQ18]
    status_word[3:0] = code_src; // [RQ19]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      can_irq <= 1'b0;
    end
    else
    begin
      can_irq <= |(int_pending_q & int_enable_q); // [RQ10] [RQ11] [RQ21]
    end
  end

  // Acceptance: frame is packed into the mask layout and compared bit for bit
  always_comb
  begin
    sel_mask = match_use_basic ? {bmask_base_q, bmask_ext_q} : {gmask_base_q, gmask_ext_q}; // [RQ3] [RQ6]
    frame_word = 32'h0000_0000;
    if (frame_ide)
    begin
      frame_word[CAM_W_ID_HI_MSB:CAM_W_ID_HI_LSB] = frame_id[28:18]; // [RQ4] [RQ7]
      frame_word[CAM_W_RTR] = frame_srr; // [RQ4] [RQ7]
      frame_word[CAM_W_IDE] = 1'b1;
      frame_word[CAM_W_ID_LO_MSB:1] = frame_id[17:0]; // [RQ9]
      frame_word[CAM_W_EXTENDED_REMOTE_MASK] = frame_rtr; // [RQ4] [RQ7]
      used_bits = CAM_EXT_USED; // [RQ4] [RQ7]
    end
    else
    begin
      frame_word[CAM_W_ID_HI_MSB:CAM_W_ID_HI_LSB] = frame_id[10:0]; // [RQ5] [RQ8]
      frame_word[CAM_W_RTR] = frame_rtr;
      frame_word[CAM_W_IDE] = 1'b0;
      used_bits = CAM_STD_USED; // [RQ5] [RQ8]
    end
    dont_care = sel_mask & used_bits; // [RQ2]
    cmp_bits = (frame_word ^ stored_word) & ~sel_mask & used_bits; // [RQ1]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      match_valid_q <= 1'b0;
      match_accept_q <= 1'b0;
      match_word_q <= 32'h0000_0000;
    end
    else
    begin
      match_valid_q <= match_req;
      if (match_req)
      begin
        match_accept_q <= (cmp_bits == 32'h0000_0000); // [RQ1]
        match_word_q <= (stored_word & ~dont_care) | (frame_word & dont_care); // [RQ2]
      end
    end
  end

  assign match_valid = match_valid_q;
  assign match_accept = match_accept_q;
  assign match_word = match_word_q;

endmodule : cam_mask_irq

/* common/cam_pkg.sv */
// Register map, field layout and encodings of the acceptance mask and interrupt block
package cam_pkg;
  localparam int CAM_NBUF = 15;
  localparam logic [7:0] CAM_ADDR_GMASK_BASE = 8'h00;
  localparam logic [7:0] CAM_ADDR_GMASK_EXT = 8'h04;
  localparam logic [7:0] CAM_ADDR_BMASK_BASE = 8'h08;
  localparam logic [7:0] CAM_ADDR_BMASK_EXT = 8'h0C;
  localparam logic [7:0] CAM_ADDR_INT_ENABLE = 8'h10;
  localparam logic [7:0] CAM_ADDR_INT_PENDING = 8'h14;
  localparam logic [7:0] CAM_ADDR_INT_CLEAR = 8'h18;
  localparam logic [7:0] CAM_ADDR_INT_CODE_EN = 8'h1C;
  localparam logic [7:0] CAM_ADDR_STATUS = 8'h20;
  localparam logic [7:0] CAM_ADDR_ERR_COUNT = 8'h24;
  localparam logic [15:0] CAM_RST_MASK_BASE = 16'h0000;
  localparam logic [15:0] CAM_RST_MASK_EXT = 16'h0000;
  localparam logic [15:0] CAM_RST_INT_ENABLE = 16'h0000;
  localparam logic [15:0] CAM_RST_INT_PENDING = 16'h0000;
  localparam logic [15:0] CAM_RST_INT_CODE_EN = 16'h0000;
  // Bit 15 of the enable, pending, clear and code-enable registers is the error source
  localparam int CAM_ERR_BIT = 15;
  // Acceptance word layout, the two mask halves joined as {base, extension}
  localparam int CAM_W_ID_HI_MSB = 31;
  localparam int CAM_W_ID_HI_LSB = 21;
  localparam int CAM_W_RTR = 20;
  localparam int CAM_W_IDE = 19;
  localparam int CAM_W_ID_LO_MSB = 18;
  localparam int CAM_W_EXTENDED_REMOTE_MASK = 0;
  // Standard frames use only the upper identifier bits, RTR and IDE
  localparam logic [31:0] CAM_STD_USED = 32'hFFF8_0000;
  localparam logic [31:0] CAM_EXT_USED = 32'hFFFF_FFFF;
  // Status register fields
  localparam int CAM_ST_NS_LSB = 8;
  localparam int CAM_ST_IRQ = 4;
  localparam logic [2:0] CAM_NS_NOT_ACTIVE = 3'h0;
  localparam logic [2:0] CAM_NS_ERR_ACTIVE = 3'h2;
  localparam logic [2:0] CAM_NS_ERR_WARNING = 3'h3;
  localparam logic [2:0] CAM_NS_ERR_PASSIVE = 3'h4;
  localparam logic [2:0] CAM_NS_BUS_OFF = 3'h6;
  localparam logic [3:0] CAM_CODE_ERROR = 4'h0;
  // Error counter thresholds and steps
  localparam logic [8:0] CAM_ERR_WARN_LVL = 9'h060;
  localparam logic [8:0] CAM_ERR_PASSIVE_LVL = 9'h080;
  localparam logic [8:0] CAM_ERR_BUSOFF_LVL = 9'h100;
  localparam logic [8:0] CAM_ERR_STEP_BIG = 9'h008;
  localparam logic [8:0] CAM_ERR_STEP_ONE = 9'h001;
endpackage : cam_pkg

/* verif/cam_mask_irq_monitor.sv */
// Port-level checks for the mask and interrupt block
module cam_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic match_req,
  input wire logic match_valid,
  input wire logic match_accept,
  input wire logic [31:0] match_word,
  input wire logic [14:0] buffer_done,
  input wire logic rx_err_inc_one,
  input wire logic rx_err_inc_big,
  input wire logic rx_err_dec,
  input wire logic tx_err_inc_big,
  input wire logic tx_err_dec,
  input wire logic bus_off_recover,
  input wire logic can_irq
);
  logic acc;
  logic set_cause;
  logic clr_cause;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign acc = psel && penable && pwrite;
  // A counter step of zero still counts as a cause, so this stays a superset
  assign set_cause = (|buffer_done) || rx_err_inc_one || rx_err_inc_big || rx_err_dec
    || tx_err_inc_big || tx_err_dec || bus_off_recover || (acc && paddr[7:2] == 6'h04);
  assign clr_cause = acc && (paddr[7:2] == 6'h04 || paddr[7:2] == 6'h06);
  sequence s_rd_clear;
    psel && !penable && !pwrite && paddr[7:2] == 6'h06;
  endsequence
  a_valid_after_req: assert property (match_req |=> match_valid)
    else $error("match result missing after request");
  a_valid_has_req: assert property (match_valid |-> $past(match_req))
    else $error("match result without request");
  a_match_holds: assert property (!match_req |=> $stable(match_word) && $stable(match_accept))
    else $error("match result changed without request");
  a_slverr_decode: assert property (psel && penable |-> pslverr == (paddr[7:2] > 6'h09))
    else $error("error response does not follow the decode");
  a_clear_reads_zero: assert property (s_rd_clear |=> prdata == 32'h0000_0000)
    else $error("clear register read back nonzero");
  a_upper_zero: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside a setup cycle");
  a_irq_rise: assert property ($rose(can_irq) |-> $past(set_cause, 2))
    else $error("interrupt rose without event or enable write");
  a_irq_fall: assert property ($fell(can_irq) |-> $past(clr_cause, 2))
    else $error("interrupt fell without clear or enable write");
endmodule : cam_monitor

bind cam_mask_irq cam_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pslverr, .match_req, .match_valid, .match_accept, .match_word, .buffer_done,
  .rx_err_inc_one, .rx_err_inc_big, .rx_err_dec, .tx_err_inc_big, .tx_err_dec,
  .bus_off_recover, .can_irq);

/* verif/cam_bus_side.sv */
// Bus-side model: received frames and transfer and error events
module cam_bus_side
(
  input wire logic pclk,
  output logic match_req,
  output logic match_use_basic,
  output logic frame_ide,
  output logic [28:0] frame_id,
  output logic frame_srr,
  output logic frame_rtr,
  output logic [31:0] stored_word,
  output logic [14:0] buffer_done,
  output logic [5:0] err_ev
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {match_req, match_use_basic, frame_ide, frame_srr, frame_rtr} = 5'h00;
    frame_id = '0;
    stored_word = '0;
    buffer_done = '0;
    err_ev = '0;
  end
  task automatic frame(input logic b, ide, srr, rtr, input logic [28:0] id,
    input logic [31:0] sw);
    @(posedge pclk);
    match_req <= 1'b1;
    match_use_basic <= b;
    {frame_ide, frame_srr, frame_rtr} <= {ide, srr, rtr};
    frame_id <= id;
    stored_word <= sw;
    @(posedge pclk);
    match_req <= 1'b0;
    // Stale identifier and stored word are inverted so a late sample cannot pass by luck
    frame_id <= ~id;
    stored_word <= ~sw;
  endtask : frame
  task automatic ev(input logic [14:0] d, input logic [5:0] e);
    @(posedge pclk);
    buffer_done <= d;
    err_ev <= e;
    @(posedge pclk);
    buffer_done <= '0;
    err_ev <= '0;
  endtask : ev
endmodule : cam_bus_side

/* verif/testbench.sv */
// Self-checking bench for the mask and interrupt block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import cam_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic node_enable = 1'b0;
  logic [31:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, match_word, stored_word, rd_v;
  logic pready, pslverr, match_req, match_use_basic, frame_ide, frame_srr, frame_rtr;
  logic match_valid, match_accept, can_irq, er_v;
  logic [28:0] frame_id;
  logic [14:0] buffer_done;
  logic [5:0] err_ev;
  logic [28:0] xid = 29'h0ABC_DEF1;
  int n_checks = 0;
  int n_mismatch = 0;
  always #5 pclk = ~pclk;
  cam_mask_irq uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .node_enable, .match_req, .match_use_basic, .frame_ide, .frame_id,
    .frame_srr, .frame_rtr, .stored_word, .match_valid, .match_accept, .match_word,
    .buffer_done, .rx_err_inc_one(err_ev[5]), .rx_err_inc_big(err_ev[4]),
    .rx_err_dec(err_ev[3]), .tx_err_inc_big(err_ev[2]), .tx_err_dec(err_ev[1]),
    .bus_off_recover(err_ev[0]), .can_irq);
  cam_bus_side u_bus (.pclk, .match_req, .match_use_basic, .frame_ide, .frame_id,
    .frame_srr, .frame_rtr, .stored_word, .buffer_done, .err_ev);
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {24'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd_v, e);
  endtask : rd
  task automatic mt(input string nm, input logic b, ide, srr, rtr, input logic [28:0] id,
    input logic [31:0] sw, input logic a, input logic [31:0] w);
    u_bus.frame(b, ide, srr, rtr, id, sw);
    #1;
    chk({nm, " valid"}, {31'h0, match_valid}, 32'h1);
    chk({nm, " accept"}, {31'h0, match_accept}, {31'h0, a});
    // Only the fields a frame type uses are defined in the merged word
    chk({nm, " word"}, match_word & (ide ? CAM_EXT_USED : CAM_STD_USED),
      w & (ide ? CAM_EXT_USED : CAM_STD_USED));
  endtask : mt
  function automatic logic [31:0] ew(logic [28:0] id, logic s, r);
    return {id[28:18], s, 1'b1, id[17:0], r};
  endfunction : ew
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++)
      rd("reset value", 8'(4 * i), 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'(4 * i), 32'hFFFF_A5C3);
      rd("mask half", 8'(4 * i), 32'h0000_A5C3);
      apb(1'b1, 8'(4 * i), 32'h0);
    end
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped error", {31'h0, er_v}, 32'h1);
    mt("std exact", 0, 0, 0, 0, 29'h5A3, 32'hB460_0000, 1, 32'hB460_0000);
    mt("std differ", 0, 0, 0, 0, 29'h5A2, 32'hB460_0000, 0, 32'hB460_0000);
    mt("std low ignored", 0, 0, 0, 0, 29'h5A3, 32'hB467_FFFF, 1, 32'hB460_0000);
    mt("basic differ", 1, 0, 0, 0, 29'h5A2, 32'hB460_0000, 0, 32'hB460_0000);
    apb(1'b1, CAM_ADDR_GMASK_BASE, 32'h0000_0020);
    mt("std dont care", 0, 0, 0, 0, 29'h5A2, 32'hB460_0000, 1, 32'hB440_0000);
    mt("basic own mask", 1, 0, 0, 0, 29'h5A2, 32'hB460_0000, 0, 32'hB460_0000);
    apb(1'b1, CAM_ADDR_BMASK_BASE, 32'h0000_0020);
    mt("basic dont care", 1, 0, 0, 0, 29'h5A2, 32'hB460_0000, 1, 32'hB440_0000);
    mt("ext exact", 0, 1, 1, 0, xid, ew(xid, 1, 0), 1, ew(xid, 1, 0));
    mt("ext id0", 0, 1, 1, 0, xid ^ 29'h1, ew(xid, 1, 0), 0, ew(xid, 1, 0));
    mt("ext srr", 0, 1, 0, 0, xid, ew(xid, 1, 0), 0, ew(xid, 1, 0));
    mt("basic ext id0", 1, 1, 1, 0, xid ^ 29'h1, ew(xid, 1, 0), 0, ew(xid, 1, 0));
    apb(1'b1, CAM_ADDR_GMASK_EXT, 32'h0000_0002);
    mt("ext id0 free", 0, 1, 1, 0, xid ^ 29'h1, ew(xid, 1, 0), 1, ew(xid ^ 29'h1, 1, 0));
    mt("ext rtr", 0, 1, 1, 1, xid, ew(xid, 1, 0), 0, ew(xid, 1, 0));
    apb(1'b1, CAM_ADDR_GMASK_EXT, 32'h0000_0003);
    mt("ext rtr free", 0, 1, 1, 1, xid, ew(xid, 1, 0), 1, ew(xid, 1, 1));
    apb(1'b1, CAM_ADDR_INT_ENABLE, 32'h0000_8008);
    apb(1'b1, CAM_ADDR_INT_CODE_EN, 32'h0000_FFFF);
    apb(1'b1, CAM_ADDR_INT_PENDING, 32'h0000_FFFF);
    u_bus.ev(15'h0028, 6'h00);
    @(posedge pclk);
    #1;
    chk("irq on", {31'h0, can_irq}, 32'h1);
    rd("pending bufs", CAM_ADDR_INT_PENDING, 32'h0000_0028);
    rd("code buf3", CAM_ADDR_STATUS, 32'h0000_0014);
    u_bus.ev(15'h0, 6'h20);
    u_bus.ev(15'h0, 6'h04);
    rd("pending err", CAM_ADDR_INT_PENDING, 32'h0000_8028);
    rd("code err", CAM_ADDR_STATUS, 32'h0000_0010);
    rd("counts", CAM_ADDR_ERR_COUNT, 32'h0000_0801);
    apb(1'b1, CAM_ADDR_INT_CLEAR, 32'h0000_0000);
    rd("clear zero", CAM_ADDR_INT_PENDING, 32'h0000_8028);
    apb(1'b1, CAM_ADDR_INT_CLEAR, 32'h0000_8008);
    rd("clear one", CAM_ADDR_INT_PENDING, 32'h0000_0020);
    rd("code buf5", CAM_ADDR_STATUS, 32'h0000_0016);
    chk("irq off", {31'h0, can_irq}, 32'h0);
    apb(1'b1, CAM_ADDR_INT_CODE_EN, 32'h0000_0008);
    rd("code masked", CAM_ADDR_STATUS, 32'h0000_0000);
    apb(1'b1, CAM_ADDR_INT_ENABLE, 32'h0000_0020);
    @(posedge pclk);
    #1;
    chk("irq buf5", {31'h0, can_irq}, 32'h1);
    apb(1'b1, CAM_ADDR_INT_CLEAR, 32'h0000_8020);
    apb(1'b1, CAM_ADDR_INT_ENABLE, 32'h0000_8000);
    node_enable <= 1'b1;
    rd("node active", CAM_ADDR_STATUS, 32'h0000_0200);
    chk("err irq idle", {31'h0, can_irq}, 32'h0);
    repeat (12) u_bus.ev(15'h0, 6'h10);
    rd("node warning", CAM_ADDR_STATUS, 32'h0000_0300);
    chk("err irq on", {31'h0, can_irq}, 32'h1);
    // Both decrements at once: receive 97 to 96, transmit 8 to 7
    u_bus.ev(15'h0, 6'h0A);
    rd("counts down", CAM_ADDR_ERR_COUNT, 32'h0000_0760);
    rd("still warning", CAM_ADDR_STATUS, 32'h0000_0300);
    repeat (16) u_bus.ev(15'h0, 6'h04);
    rd("node passive", CAM_ADDR_STATUS, 32'h0000_0400);
    repeat (16) u_bus.ev(15'h0, 6'h04);
    rd("node bus off", CAM_ADDR_STATUS, 32'h0000_0600);
    u_bus.ev(15'h0, 6'h01);
    rd("recovered", CAM_ADDR_STATUS, 32'h0000_0200);
    rd("counts cleared", CAM_ADDR_ERR_COUNT, 32'h0000_0000);
    summarize();
  end
endmodule : testbench
